// File: did_decoder.sv
// Instruction word decoder and cycle timer with an APB register slave
//
// How it works
// (RQ1) Single words are 24 bits; the top 8 bits are the opcode.
// (RQ2) Two-word instructions take 48 bits; second word top 8 bits must be zero.
// (RQ3) A second word executed alone is a no-operation and changes nothing.
// (RQ4) Exactly three opcodes span two words; all others are one word.
// (RQ5) One cycle normally; two when a test is true or PC changes, extra is a NOP.
// (RQ6) Branches, indirect call/jump, table ops and returns take two or three cycles.
// (RQ7) A taken skip costs two cycles, three when the skipped word is two-word.
// (RQ8) Double-word moves and all two-word instructions take exactly two cycles.
// (RQ9) File register address spans 0 to 0x1FFF.
// (RQ10) Destination bit sends the result to the file register or register zero.
// (RQ11) Base register field picks one of sixteen working registers, unmodified.
// (RQ12) Accumulator select picks A or B.
// (RQ13) Write-back goes to register thirteen or its location with post-increment by 2.
// (RQ14) Bit select is a 4-bit field choosing bit 0 to 15.
// (RQ15) Ten-bit unsigned literal is 0..255 in byte mode, 0..1023 in word mode.
// (RQ16) The 23-bit program address literal always has its low bit zero.
// (RQ17) Ten-bit signed literal is two's complement, -512 to 511.
// (RQ18) Five core and four DSP flags; only the affected ones are updated.
//
// The placing of the registers and the APB register port were decided locally.
`include "did_consts.svh"
`default_nettype none
module did_decoder (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             instr_cycle,
   output logic             nop_cycle,
   output logic             instr_done,
   output logic             busy
);

   function automatic did_pkg::did_class_t class_of(input logic [7:0] opc);
      did_pkg::did_class_t cls;
      cls = did_pkg::DID_CLS_SIMPLE;
      if (opc == `DID_OPC_CALL || opc == `DID_OPC_GOTO || opc == `DID_OPC_DO) begin
         cls = did_pkg::DID_CLS_TWOW; // RQ4
      end else if (opc == `DID_OPC_DMOV) begin
         cls = did_pkg::DID_CLS_DMOV;
      end else if (opc == `DID_OPC_BRA || opc == `DID_OPC_CALLW || opc == `DID_OPC_GOTOW
                   || opc == `DID_OPC_RETURN || opc == `DID_OPC_INTERRUPT_RETURN_INSTR
                   || opc[7:4] == `DID_OPC_TBL_HI) begin
         cls = did_pkg::DID_CLS_FLOW;
      end else if (opc[7:4] == `DID_OPC_BCC_HI) begin
         cls = did_pkg::DID_CLS_COND;
      end else if (opc[7:4] == `DID_OPC_SKIP_HI) begin
         cls = did_pkg::DID_CLS_SKIP;
      end
      return cls;
   endfunction

   // Total instruction cycles for one decoded instruction
   function automatic logic [1:0] cycles_of(input did_pkg::did_class_t cls,
                                            input logic [4:0] ctl);
      logic [1:0] n;
      n = 2'd1;
      case (cls)
         did_pkg::DID_CLS_COND: begin
            n = ctl[`DID_CTRL_COND] ? 2'd2 : 2'd1; // RQ5
         end
         did_pkg::DID_CLS_SKIP: begin
            if (ctl[`DID_CTRL_SKIP]) begin
               n = ctl[`DID_CTRL_SKIP2W] ? 2'd3 : 2'd2; // RQ7
            end
         end
         did_pkg::DID_CLS_FLOW: begin
            n = ctl[`DID_CTRL_EXTRA] ? 2'd3 : 2'd2; // RQ6
         end
         did_pkg::DID_CLS_TWOW: begin
            n = 2'd2; // RQ8
         end
         did_pkg::DID_CLS_DMOV: begin
            n = 2'd2; // RQ8
         end
         default: begin
            n = 2'd1; // RQ5
         end
      endcase
      return n;
   endfunction

   did_pkg::did_state_t state_r;
   logic [4:0]          ctrl_r;
   logic [23:0]         word0_r;
   logic [6:0]          addr_hi_r;
   logic [1:0]          cyc_left_r;
   logic [1:0]          cyc_total_r;
   logic [7:0]          opcode_r;
   logic [3:0]          base_work_reg_r;
   logic [3:0]          dest_work_reg_r;
   logic [3:0]          source_work_reg_r;
   logic [3:0]          bit_select_field_r;
   logic [12:0]         file_addr_r;
   logic                to_file_op_default_reg_r;
   logic                acc_sel_b_r;
   logic                acc_writeback_dest_r;
   logic [9:0]          unsigned_literal_ten_r;
   logic [15:0]         signed_literal_ten_r;
   logic [22:0]         unsigned_literal_twentythree_r;
   logic                lone_second_r;
   logic                second_err_r;
   logic [8:0]          flags_r;
   logic [17:0]         flag_upd_r;
   logic [31:0]         rdata_nxt;
   logic                mapped;
   logic                access;
   logic                commit;
   logic                stall_instr;
   logic                instr_wr;
   logic [23:0]         iw;
   did_pkg::did_class_t iw_cls;

   assign access   = psel && penable;
   assign commit   = access && pready;
   // An instruction write cannot be taken while the previous one still runs
   assign stall_instr = pwrite && paddr == `DID_OFS_INSTR && state_r == did_pkg::DID_ST_EXEC;
   assign iw       = pwdata[23:0];
   assign iw_cls   = class_of(iw[`DID_OPC_HI:`DID_OPC_LO]); // RQ1
   assign instr_wr = commit && pwrite && paddr == `DID_OFS_INSTR && !pslverr;

   always_comb begin
      mapped    = 1'b1;
      rdata_nxt = 32'h0000_0000;
      case (paddr)
         `DID_OFS_INSTR: begin
            rdata_nxt = {8'h00, word0_r};
         end
         `DID_OFS_CTRL: begin
            rdata_nxt = {27'h0, ctrl_r};
         end
         `DID_OFS_STATUS: begin
            rdata_nxt = {16'h0, opcode_r, 1'b0, second_err_r, lone_second_r,
                         state_r == did_pkg::DID_ST_WAIT2, cyc_total_r, cyc_left_r};
         end
         `DID_OFS_WREGS: begin
            rdata_nxt = {16'h0, bit_select_field_r, base_work_reg_r,
                         dest_work_reg_r, source_work_reg_r};
         end
         `DID_OFS_FILEOP: begin
            rdata_nxt = {16'h0, acc_sel_b_r, acc_writeback_dest_r,
                         to_file_op_default_reg_r, file_addr_r};
         end
         `DID_OFS_LITS: begin
            rdata_nxt = {signed_literal_ten_r, 6'h00, unsigned_literal_ten_r};
         end
         `DID_OFS_PADDR: begin
            rdata_nxt = {9'h000, unsigned_literal_twentythree_r};
         end
         `DID_OFS_FLAGS: begin
            rdata_nxt = {23'h0, flags_r};
         end
         `DID_OFS_FLAGUPD: begin
            rdata_nxt = {7'h00, flag_upd_r[17:9], 7'h00, flag_upd_r[8:0]};
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // APB answer: ready one cycle into the access phase; an instruction write
   // stalls while the previous instruction is still running its cycles.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (access && !pready && !stall_instr) begin
         pready  <= 1'b1;
         pslverr <= !mapped;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Read data only moves with an answer, so it stands still between transfers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (access && !pready && !stall_instr) begin
         prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
      end
   end

   // Control is read when an instruction is accepted, so it must be set first
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_r <= `DID_CTRL_RST;
      end else if (commit && pwrite && paddr == `DID_OFS_CTRL) begin
         ctrl_r <= pwdata[4:0];
      end
   end

   // Affect mask in the upper half, new flag values in the lower half
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_upd_r <= 18'h00000;
      end else if (commit && pwrite && paddr == `DID_OFS_FLAGUPD) begin
         flag_upd_r <= {pwdata[24:16], pwdata[8:0]};
      end
   end

   // Instruction sequencing and cycle counting
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r     <= did_pkg::DID_ST_IDLE;
         cyc_left_r  <= 2'd0;
         cyc_total_r <= 2'd0;
      end else begin
         case (state_r)
            did_pkg::DID_ST_IDLE: begin
               if (instr_wr) begin
                  if (iw_cls == did_pkg::DID_CLS_TWOW) begin
                     state_r <= did_pkg::DID_ST_WAIT2; // RQ2
                  end else begin
                     state_r     <= did_pkg::DID_ST_EXEC;
                     cyc_left_r  <= cycles_of(iw_cls, ctrl_r);
                     cyc_total_r <= cycles_of(iw_cls, ctrl_r);
                  end
               end
            end
            did_pkg::DID_ST_WAIT2: begin
               if (instr_wr) begin
                  state_r      <= did_pkg::DID_ST_EXEC;
                  cyc_left_r   <= cycles_of(did_pkg::DID_CLS_TWOW, ctrl_r); // RQ8
                  cyc_total_r  <= cycles_of(did_pkg::DID_CLS_TWOW, ctrl_r);
               end
            end
            did_pkg::DID_ST_EXEC: begin
               cyc_left_r <= cyc_left_r - 2'd1;
               if (cyc_left_r == 2'd1) begin
                  state_r <= did_pkg::DID_ST_IDLE;
               end
            end
            default: begin
               state_r <= did_pkg::DID_ST_IDLE;
            end
         endcase
      end
   end

   // First word of each instruction; a lone second word marks a NOP
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         word0_r       <= 24'h000000;
         lone_second_r <= 1'b0;
      end else if (instr_wr && state_r == did_pkg::DID_ST_IDLE) begin
         word0_r       <= iw;
         lone_second_r <= iw[`DID_OPC_HI:`DID_OPC_LO] == `DID_OPC_NOP; // RQ3
      end
   end

   // A bad second word still completes, flagged for software
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         second_err_r <= 1'b0;
         addr_hi_r    <= 7'h00;
      end else if (instr_wr && state_r == did_pkg::DID_ST_IDLE) begin
         second_err_r <= 1'b0;
      end else if (instr_wr && state_r == did_pkg::DID_ST_WAIT2) begin
         second_err_r <= iw[`DID_OPC_HI:`DID_OPC_LO] != 8'h00; // RQ2
         addr_hi_r    <= iw[6:0];
      end
   end

   // Operand fields, latched from the first word of each instruction other than a lone second word (NOP)
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         opcode_r                 <= 8'h00;
         base_work_reg_r          <= 4'h0;
         dest_work_reg_r          <= 4'h0;
         source_work_reg_r        <= 4'h0;
         bit_select_field_r       <= 4'h0;
         file_addr_r              <= 13'h0000;
         to_file_op_default_reg_r <= 1'b0;
         acc_sel_b_r              <= 1'b0;
         acc_writeback_dest_r     <= 1'b0;
         unsigned_literal_ten_r   <= 10'h000;
         signed_literal_ten_r     <= 16'h0000;
      end else if (instr_wr && state_r == did_pkg::DID_ST_IDLE
                   && iw[`DID_OPC_HI:`DID_OPC_LO] != `DID_OPC_NOP) begin
         opcode_r                 <= iw[`DID_OPC_HI:`DID_OPC_LO]; // RQ1
         base_work_reg_r          <= iw[`DID_BASE_HI:`DID_BASE_LO]; // RQ11
         dest_work_reg_r          <= iw[`DID_DWR_HI:`DID_DWR_LO];
         source_work_reg_r        <= iw[`DID_SWR_HI:0];
         bit_select_field_r       <= iw[`DID_BITSEL_HI:`DID_BITSEL_LO]; // RQ14
         file_addr_r              <= iw[`DID_FADDR_HI:0] & `DID_FADDR_MAX; // RQ9
         to_file_op_default_reg_r <= !iw[`DID_DEST_BIT]; // RQ10
         acc_sel_b_r              <= iw[`DID_ACC_BIT]; // RQ12
         acc_writeback_dest_r     <= iw[`DID_AWB_BIT]; // RQ13
         // Byte mode keeps only the low eight bits of the literal
         unsigned_literal_ten_r   <= ctrl_r[`DID_CTRL_BYTE]
                                     ? (iw[`DID_LIT_HI:`DID_LIT_LO] & `DID_BYTE_LIT_MAX)
                                     : iw[`DID_LIT_HI:`DID_LIT_LO]; // RQ15
         signed_literal_ten_r     <= {{6{iw[`DID_LIT_HI]}},
                                      iw[`DID_LIT_HI:`DID_LIT_LO]}; // RQ17
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         unsigned_literal_twentythree_r <= 23'h000000;
      end else if (state_r == did_pkg::DID_ST_EXEC && cyc_left_r == cyc_total_r
                   && class_of(word0_r[`DID_OPC_HI:`DID_OPC_LO]) == did_pkg::DID_CLS_TWOW) begin
         unsigned_literal_twentythree_r <= {addr_hi_r, word0_r[15:1], 1'b0}; // RQ16
      end
   end

   // Flags: bits 8..4 are C, DC, N, OV, Z; bits 3..0 are the DSP A/B flags.
   // Z is sticky: an instruction can only clear it, never set it.
   // A software write wins over an instruction update in the same cycle.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flags_r <= `DID_FLAGS_RST;
      end else if (commit && pwrite && paddr == `DID_OFS_FLAGS) begin
         flags_r <= pwdata[8:0];
      end else if (state_r == did_pkg::DID_ST_EXEC && cyc_left_r == 2'd1 && !lone_second_r) begin
         for (int i = 0; i < 9; i++) begin
            if (flag_upd_r[9 + i]) begin
               flags_r[i] <= (i == 4) ? (flags_r[i] & flag_upd_r[i]) : flag_upd_r[i]; // RQ18
            end
         end
      end
   end

   // Cycle strobes to the datapath; cycles after the first are NOPs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         instr_cycle <= 1'b0;
      end else begin
         instr_cycle <= state_r == did_pkg::DID_ST_EXEC;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         nop_cycle <= 1'b0;
      end else begin
         nop_cycle <= state_r == did_pkg::DID_ST_EXEC
                      && (cyc_left_r != cyc_total_r || lone_second_r); // RQ5 RQ3
      end
   end

   // Done is a one-cycle pulse, level with the last instruction cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         instr_done <= 1'b0;
      end else begin
         instr_done <= state_r == did_pkg::DID_ST_EXEC && cyc_left_r == 2'd1;
      end
   end

   // Busy also covers the wait for a second word
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy <= 1'b0;
      end else begin
         busy <= state_r != did_pkg::DID_ST_IDLE;
      end
   end

endmodule
`default_nettype wire

// File: did_consts.svh
// Register offsets, field positions, reset values and opcode groups of the decoder
`ifndef DID_CONSTS_SVH
`define DID_CONSTS_SVH

`define DID_OFS_INSTR    12'h000
`define DID_OFS_CTRL     12'h004
`define DID_OFS_STATUS   12'h008
`define DID_OFS_WREGS    12'h00C
`define DID_OFS_FILEOP   12'h010
`define DID_OFS_LITS     12'h014
`define DID_OFS_PADDR    12'h018
`define DID_OFS_FLAGS    12'h01C
`define DID_OFS_FLAGUPD  12'h020

`define DID_OPC_HI       23
`define DID_OPC_LO       16
`define DID_FADDR_HI     12
`define DID_DEST_BIT     13
`define DID_BASE_HI      14
`define DID_BASE_LO      11
`define DID_DWR_HI       10
`define DID_DWR_LO       7
`define DID_SWR_HI       3
`define DID_BITSEL_HI    15
`define DID_BITSEL_LO    12
`define DID_ACC_BIT      15
`define DID_AWB_BIT      14
`define DID_LIT_HI       13
`define DID_LIT_LO       4

`define DID_CTRL_COND    0
`define DID_CTRL_SKIP    1
`define DID_CTRL_SKIP2W  2
`define DID_CTRL_BYTE    3
`define DID_CTRL_EXTRA   4

`define DID_FLAGS_RST    9'h000
`define DID_CTRL_RST     5'h00
`define DID_BYTE_LIT_MAX 10'h0FF
`define DID_FADDR_MAX    13'h1FFF

`define DID_OPC_NOP      8'h00
`define DID_OPC_CALL     8'h02
`define DID_OPC_GOTO     8'h04
`define DID_OPC_DO       8'h08
`define DID_OPC_BRA      8'h37
`define DID_OPC_DMOV     8'hBE
`define DID_OPC_CALLW    8'h01
`define DID_OPC_GOTOW    8'h05
`define DID_OPC_RETURN   8'h06
`define DID_OPC_INTERRUPT_RETURN_INSTR   8'h07
`define DID_OPC_TBL_HI   4'hB
`define DID_OPC_BCC_HI   4'h3
`define DID_OPC_SKIP_HI  4'hA

`endif

// File: did_pkg.sv
// Types shared by the instruction decode and timing block
`default_nettype none
package did_pkg;
   typedef enum logic [2:0] {
      DID_CLS_SIMPLE = 3'b000,
      DID_CLS_COND   = 3'b001,
      DID_CLS_SKIP   = 3'b010,
      DID_CLS_FLOW   = 3'b011,
      DID_CLS_TWOW   = 3'b100,
      DID_CLS_DMOV   = 3'b101
   } did_class_t;

   typedef enum logic [1:0] {
      DID_ST_IDLE  = 2'b00,
      DID_ST_WAIT2 = 2'b01,
      DID_ST_EXEC  = 2'b10
   } did_state_t;
endpackage
`default_nettype wire

// File: did_decoder_monitor.sv
// Port-level assertions for the instruction decode and timing block
`default_nettype none
module did_decoder_monitor (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        instr_cycle,
   input wire logic        nop_cycle,
   input wire logic        instr_done,
   input wire logic        busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] run_cnt_r;

   // Cycles already spent by the running instruction; saturates so a hang still fails
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         run_cnt_r <= 2'h0;
      end else if (instr_done) begin
         run_cnt_r <= 2'h0;
      end else if (instr_cycle && run_cnt_r != 2'h3) begin
         run_cnt_r <= run_cnt_r + 2'h1;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_pending;
      psel && penable && !pready;
   endsequence
   sequence s_answer;
      ##[1:6] pready;
   endsequence

   AST_APB_ANSWER: assert property (s_pending |-> s_answer)
      else $error("bus access not answered in time");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_READY_CAUSE: assert property (pready |-> $past(psel && penable))
      else $error("pready without access phase");
   AST_ERR_DECODE: assert property (pready |->
      (pslverr == ($past(paddr) > 12'h020 || $past(paddr[1:0]) != 2'h0)))
      else $error("pslverr does not match address map");
   AST_ERR_QUAL: assert property (pslverr |-> pready)
      else $error("pslverr outside answer");
   AST_ERR_NO_DATA: assert property (pready && pslverr && !$past(pwrite) |-> prdata == 32'h0)
      else $error("unmapped read returned data");
   AST_DONE_IN_CYCLE: assert property (instr_done |-> instr_cycle)
      else $error("done outside an instruction cycle");
   AST_CYCLE_BUSY: assert property (instr_cycle |-> busy)
      else $error("instruction cycle while idle");
   AST_NOP_IN_CYCLE: assert property (nop_cycle |-> instr_cycle)
      else $error("nop flag outside an instruction cycle");
   AST_MAX_THREE: assert property (instr_cycle |-> run_cnt_r <= 2'h2)
      else $error("instruction longer than three cycles");
endmodule
`default_nettype wire

// File: did_fetch_model.sv
// Fetch unit model: hands instruction words and register accesses to the decoder
`default_nettype none
module did_fetch_model (
   input  wire logic        clk,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [31:0] prdata,
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [11:0] paddr,
   output var  logic [31:0] pwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end

   // Starts one edge late so a release and the next setup never share a time step
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Waits as long as the slave stalls; only the bench watchdog ends a hang
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: did_decoder_bench.sv
// Self-checking bench for the instruction decode and timing block
`include "did_consts.svh"
`default_nettype none
module did_decoder_bench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [4:0]  ctrl;
      logic [23:0] instr;
      logic [1:0]  cyc;
      logic [1:0]  nop;
   } did_row_t;
   logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, er;
   logic        instr_cycle, nop_cycle, instr_done, busy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int          error_cnt, checks_done, cyc_seen, nop_seen;
   logic [7:0]  two_opc [3] = '{8'h02, 8'h04, 8'h08};
   // Every cycle after the first is a NOP
   did_row_t    rows [15] = '{
      '{5'h00, 24'h400000, 2'd1, 2'd0}, '{5'h01, 24'h300000, 2'd2, 2'd1},
      '{5'h00, 24'h300000, 2'd1, 2'd0}, '{5'h00, 24'h370000, 2'd2, 2'd1},
      '{5'h10, 24'h370000, 2'd3, 2'd2}, '{5'h00, 24'h010000, 2'd2, 2'd1},
      '{5'h00, 24'h050000, 2'd2, 2'd1}, '{5'h00, 24'h060000, 2'd2, 2'd1},
      '{5'h00, 24'h070000, 2'd2, 2'd1}, '{5'h00, 24'hB00000, 2'd2, 2'd1},
      '{5'h02, 24'hA00000, 2'd2, 2'd1}, '{5'h06, 24'hA00000, 2'd3, 2'd2},
      '{5'h00, 24'hA00000, 2'd1, 2'd0}, '{5'h00, 24'hBE0000, 2'd2, 2'd1},
      '{5'h00, 24'h000000, 2'd1, 2'd1}};

   did_decoder dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .instr_cycle(instr_cycle), .nop_cycle(nop_cycle),
      .instr_done(instr_done), .busy(busy));
   did_fetch_model fetch (.clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

   always #20 clk = ~clk;

   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      fetch.xfer(1'b1, a, d, rd, er);
   endtask

   task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
      fetch.xfer(1'b0, a, 32'h0, rd, er);
      check(name, rd, exp);
   endtask

   // Counts instruction and nop cycles until the last cycle shows done
   task automatic count;
      cyc_seen = 0;
      nop_seen = 0;
      for (int n = 0; n < 20; n++) begin
         #1;
         if (instr_cycle === 1'b1) cyc_seen++;
         if (nop_cycle === 1'b1) nop_seen++;
         if (instr_done === 1'b1) break;
         @(posedge clk);
      end
   endtask

   task automatic run(input logic [4:0] c, input logic [23:0] w);
      wr(`DID_OFS_CTRL, {27'h0, c});
      wr(`DID_OFS_INSTR, {8'h00, w});
      count();
   endtask

   task automatic summarize;
      if (error_cnt == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      #200000;
      error_cnt++;
      summarize();
   end

   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      error_cnt = 0;
      checks_done = 0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      rdc("flags_rst", `DID_OFS_FLAGS, {23'h0, `DID_FLAGS_RST});
      rdc("ctrl_rst", `DID_OFS_CTRL, {27'h0, `DID_CTRL_RST});
      foreach (rows[i]) begin
         run(rows[i].ctrl, rows[i].instr);
         check("cycles", cyc_seen, rows[i].cyc);
         check("nops", nop_seen, rows[i].nop);
      end
      foreach (two_opc[k]) begin
         wr(`DID_OFS_INSTR, {8'h00, two_opc[k], 16'hABCD});
         @(posedge clk);
         #1 check("wait_second", busy, 1'b1);
         // Second word carries a zero top byte, odd first word still gives an even address
         wr(`DID_OFS_INSTR, 32'h0000005B);
         count();
         check("two_word_cycles", cyc_seen, 2);
         rdc("prog_addr", `DID_OFS_PADDR, 32'h005BABCC);
      end
      run(5'h00, 24'h401FFF);
      rdc("fileop_max", `DID_OFS_FILEOP, 32'h00003FFF);
      rdc("wregs_a", `DID_OFS_WREGS, 32'h000013FF);
      rdc("lits_word", `DID_OFS_LITS, 32'h01FF01FF);
      run(5'h08, 24'h401FFF);
      rdc("lits_byte", `DID_OFS_LITS, 32'h01FF00FF);
      wr(`DID_OFS_FLAGS, 32'h0);
      wr(`DID_OFS_FLAGUPD, 32'h011101FF);
      run(5'h00, 24'h40E000);
      rdc("fileop_b", `DID_OFS_FILEOP, 32'h0000C000);
      rdc("wregs_b", `DID_OFS_WREGS, 32'h0000EC00);
      rdc("lits_neg", `DID_OFS_LITS, 32'hFE000200);
      rdc("flags_upd", `DID_OFS_FLAGS, 32'h00000101);
      wr(`DID_OFS_FLAGS, 32'h0);
      run(5'h00, 24'h000000);
      rdc("flags_nop", `DID_OFS_FLAGS, 32'h0);
      rdc("wregs_nop", `DID_OFS_WREGS, 32'h0000EC00);
      fetch.xfer(1'b0, 12'h024, 32'h0, rd, er);
      check("unmapped_err", er, 1'b1);
      check("unmapped_data", rd, 32'h0);
      wr(`DID_OFS_CTRL, 32'h10);
      wr(`DID_OFS_INSTR, 32'h370000);
      // Stalls until the three-cycle branch has ended, then runs
      wr(`DID_OFS_INSTR, 32'h400000);
      count();
      check("stalled_instr", cyc_seen, 1);
      wr(`DID_OFS_INSTR, 32'h020000);
      wr(`DID_OFS_INSTR, 32'hFF0000);
      count();
      check("bad2_cycles", cyc_seen, 2);
      rdc("status_bad2", `DID_OFS_STATUS, 32'h00000248);
      wr(`DID_OFS_INSTR, 32'h040000);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      #1 check("busy_rst", busy, 1'b0);
      rdc("status_rst", `DID_OFS_STATUS, 32'h0);
      rdc("ctrl_rst2", `DID_OFS_CTRL, {27'h0, `DID_CTRL_RST});
      summarize();
   end
endmodule

bind did_decoder did_decoder_monitor mon (.clk(clk), .rst_b(rst_b), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .instr_cycle(instr_cycle), .nop_cycle(nop_cycle),
   .instr_done(instr_done), .busy(busy));
`default_nettype wire
